// [rtl/pnl_output_control.sv]
// Panel and CRT output control with its AHB-Lite register slave.
// Operation
// - DAC off while misc bit 7 set.
// - Extension bit 4 selects extended I/O cycle.
// - Reverse video on mono panels: both, text only, none.
// - Display select high only for CRT-only.
// - Simultaneous display keeps expansion and centering.
// - Extension bit 2 puts CRT sync on direction pins.
// - TFT enabled forces active-low CRT syncs.
// - Extension bit 1 inverts frame pulse.
// - Extension bit 0 inverts line pulse.
// - Horizontal sync delayed zero to seven video clocks.
// - Dither clock stopped when dithering unneeded.
// - Panel data low in reset and power-down.
// - MEMCS16 released on pin power-down with bus bit 5.
// - Line pulses in vertical blanking selectable, all panels.
// - STN colour panels get 4K colour path.
`timescale 1ns/100ps
`default_nettype none
`include "pnl_regs.svh"
module pnl_output_control (
	// Clock and reset.
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave.
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Video timing and data from the display core, plus direction, MEMCS16 and power-down inputs.
	input wire logic video_clock,
	input wire logic crt_hsync_in,
	input wire logic crt_vsync_in,
	input wire logic frame_pulse_in,
	input wire logic line_pulse_in,
	input wire logic vblank_in,
	input wire logic text_mode_in,
	input wire pnl_pkg::pnl_nib_t upper_data_in,
	input wire pnl_pkg::pnl_nib_t lower_data_in,
	input wire logic low_dir_in,
	input wire logic high_dir_in,
	input wire logic memcs16_in,
	input wire logic power_down_n_input,
	// Panel and CRT pins.
	output pnl_pkg::pnl_nib_t upper_panel_data,
	output pnl_pkg::pnl_nib_t lower_panel_data,
	output logic frame_pulse,
	output logic line_pulse,
	output logic crt_hsync,
	output logic crt_vsync,
	output logic low_byte_direction,
	output logic high_byte_direction,
	output logic display_select_out,
	output logic memcs16_o,
	output logic memcs16_oe_n,
	// Control to the rest of the chip.
	output logic dac_shutdown,
	output logic io_cycle_ext,
	output logic dither_clk_en,
	output logic color_4k_mode,
	output logic vexp_center_en,
	output logic panel_enable,
	output logic crt_enable
);
	import pnl_pkg::*;

	pnl_dly_if dly_link ();

	// Register group.
	pnl_byte_t misc_r, misc_nxt;
	pnl_byte_t adj_r, adj_nxt;
	pnl_byte_t ext_r, ext_nxt;
	pnl_byte_t pwr_r, pwr_nxt;
	pnl_byte_t cfg_r, cfg_nxt;
	pnl_byte_t mout_r, mout_nxt;
	logic wr_pend_r, wr_pend_nxt;
	logic [7:0] wr_addr_r, wr_addr_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic addr_phase;

	// Retimed configuration, updated on video clock enables.
	pnl_byte_t ext_v_r, ext_v_nxt;
	pnl_byte_t adj_v_r, adj_v_nxt;
	pnl_byte_t mout_v_r, mout_v_nxt;
	pnl_byte_t cfg_v_r, cfg_v_nxt;
	pnl_byte_t misc_v_r, misc_v_nxt;

	// Output group.
	pnl_nib_t upd_r, upd_nxt;
	pnl_nib_t lpd_r, lpd_nxt;
	logic fp_r, fp_nxt;
	logic lp_r, lp_nxt;
	logic hs_r, hs_nxt;
	logic vs_r, vs_nxt;
	logic lbd_r, lbd_nxt;
	logic hbd_r, hbd_nxt;
	logic dsel_r, dsel_nxt;
	logic mcs_r, mcs_nxt;
	logic mcs_oe_n_r, mcs_oe_n_nxt;

	pnl_mode_t mode_v;
	logic powered_down;
	logic reverse_now;
	logic hsync_pol;
	logic vsync_pol;
	logic panel_on;
	logic crt_on;

	assign addr_phase = hsel && htrans[1] && hready;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = rdata_r;

	always_comb begin
		misc_nxt = misc_r;
		adj_nxt = adj_r;
		ext_nxt = ext_r;
		pwr_nxt = pwr_r;
		cfg_nxt = cfg_r;
		mout_nxt = mout_r;
		wr_pend_nxt = addr_phase && hwrite;
		wr_addr_nxt = addr_phase ? haddr : wr_addr_r;
		rdata_nxt = rdata_r;
		if (wr_pend_r) begin
			if (wr_addr_r == `PNL_OFS_MISC) begin
				misc_nxt = hwdata[7:0];
			end else if (wr_addr_r == `PNL_OFS_SYNC_ADJ) begin
				adj_nxt = hwdata[7:0];
			end else if (wr_addr_r == `PNL_OFS_EXT) begin
				ext_nxt = hwdata[7:0];
			end else if (wr_addr_r == `PNL_OFS_BUS_PWR) begin
				pwr_nxt = hwdata[7:0];
			end else if (wr_addr_r == `PNL_OFS_PANEL_CFG) begin
				cfg_nxt = hwdata[7:0];
			end else if (wr_addr_r == `PNL_OFS_MISC_OUT) begin
				mout_nxt = hwdata[7:0];
			end
		end
		if (addr_phase && !hwrite) begin
			if (haddr == `PNL_OFS_MISC) begin
				rdata_nxt = {24'h000000, misc_r};
			end else if (haddr == `PNL_OFS_SYNC_ADJ) begin
				rdata_nxt = {24'h000000, adj_r};
			end else if (haddr == `PNL_OFS_EXT) begin
				rdata_nxt = {24'h000000, ext_r};
			end else if (haddr == `PNL_OFS_BUS_PWR) begin
				rdata_nxt = {24'h000000, pwr_r};
			end else if (haddr == `PNL_OFS_PANEL_CFG) begin
				rdata_nxt = {24'h000000, cfg_r};
			end else if (haddr == `PNL_OFS_MISC_OUT) begin
				rdata_nxt = {24'h000000, mout_r};
			end else if (haddr == `PNL_OFS_STATUS) begin
				rdata_nxt = {24'h000000, powered_down, mcs_oe_n_r, dsel_r, lbd_r, hbd_r,
					hs_r, vs_r, reverse_now};
			end else begin
				rdata_nxt = 32'h00000000;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			misc_r <= `PNL_RST_MISC;
			adj_r <= `PNL_RST_SYNC_ADJ;
			ext_r <= `PNL_RST_EXT;
			pwr_r <= `PNL_RST_BUS_PWR;
			cfg_r <= `PNL_RST_PANEL_CFG;
			mout_r <= `PNL_RST_MISC_OUT;
			wr_pend_r <= 1'b0;
			wr_addr_r <= 8'h00;
			rdata_r <= 32'h00000000;
		end else begin
			misc_r <= misc_nxt;
			adj_r <= adj_nxt;
			ext_r <= ext_nxt;
			pwr_r <= pwr_nxt;
			cfg_r <= cfg_nxt;
			mout_r <= mout_nxt;
			wr_pend_r <= wr_pend_nxt;
			wr_addr_r <= wr_addr_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	always_comb begin
		ext_v_nxt = ext_v_r;
		adj_v_nxt = adj_v_r;
		mout_v_nxt = mout_v_r;
		cfg_v_nxt = cfg_v_r;
		misc_v_nxt = misc_v_r;
		if (video_clock) begin
			ext_v_nxt = ext_r;
			adj_v_nxt = adj_r;
			mout_v_nxt = mout_r;
			cfg_v_nxt = cfg_r;
			misc_v_nxt = misc_r;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ext_v_r <= `PNL_RST_EXT;
			adj_v_r <= `PNL_RST_SYNC_ADJ;
			mout_v_r <= `PNL_RST_MISC_OUT;
			cfg_v_r <= `PNL_RST_PANEL_CFG;
			misc_v_r <= `PNL_RST_MISC;
		end else begin
			ext_v_r <= ext_v_nxt;
			adj_v_r <= adj_v_nxt;
			mout_v_r <= mout_v_nxt;
			cfg_v_r <= cfg_v_nxt;
			misc_v_r <= misc_v_nxt;
		end
	end

	assign mode_v = pnl_mode_t'(cfg_v_r[`PNL_CFG_MODE_HI:`PNL_CFG_MODE_LO]);
	assign powered_down = !power_down_n_input || cfg_r[`PNL_CFG_SW_PWRDN];
	assign panel_on = (mode_v == PNL_MODE_PANEL) || (mode_v == PNL_MODE_SIMUL);
	assign crt_on = (mode_v == PNL_MODE_CRT) || (mode_v == PNL_MODE_SIMUL);
	assign panel_enable = panel_on;
	assign crt_enable = crt_on;
	assign vexp_center_en = panel_on && cfg_v_r[`PNL_CFG_VEXP];

	assign dac_shutdown = misc_r[`PNL_MISC_DAC_OFF];
	assign io_cycle_ext = ext_r[`PNL_EXT_IO_EXT];
	assign dither_clk_en = video_clock && panel_on && !powered_down
		&& cfg_v_r[`PNL_CFG_STN_COLOR];
	assign color_4k_mode = panel_on && cfg_v_r[`PNL_CFG_STN_COLOR];

	assign reverse_now = cfg_v_r[`PNL_CFG_MONO] && misc_v_r[`PNL_MISC_REVERSE]
		&& (text_mode_in || !ext_v_r[`PNL_EXT_TEXT_ONLY]);

	assign hsync_pol = cfg_v_r[`PNL_CFG_TFT] || mout_v_r[`PNL_MOUT_HSYNC_NEG];
	assign vsync_pol = cfg_v_r[`PNL_CFG_TFT] || mout_v_r[`PNL_MOUT_VSYNC_NEG];

	assign dly_link.video_clock_en = video_clock;
	assign dly_link.sync_in = crt_hsync_in;
	assign dly_link.delay = {adj_v_r[`PNL_ADJ_DLY_MSB], adj_v_r[`PNL_ADJ_DLY_B1],
		adj_v_r[`PNL_ADJ_DLY_B0]};

	pnl_hsync_delay u_dly (
		.hclk(hclk),
		.hresetn(hresetn),
		.dl(dly_link.dly)
	);

	always_comb begin
		upd_nxt = upd_r;
		lpd_nxt = lpd_r;
		fp_nxt = fp_r;
		lp_nxt = lp_r;
		hs_nxt = hs_r;
		vs_nxt = vs_r;
		if (video_clock) begin
			upd_nxt = upper_data_in ^ {4{reverse_now}};
			lpd_nxt = lower_data_in ^ {4{reverse_now}};
			fp_nxt = frame_pulse_in ^ ext_v_r[`PNL_EXT_FP_INV];
			lp_nxt = (line_pulse_in && (!vblank_in || cfg_v_r[`PNL_CFG_LP_VBLANK]))
				^ ext_v_r[`PNL_EXT_LP_INV];
			hs_nxt = dly_link.sync_out ^ hsync_pol;
			vs_nxt = crt_vsync_in ^ vsync_pol;
		end
		if (powered_down) begin
			upd_nxt = 4'h0;
			lpd_nxt = 4'h0;
		end
		if (ext_v_r[`PNL_EXT_SYNC_MUX]) begin
			lbd_nxt = vs_nxt;
			hbd_nxt = hs_nxt;
		end else begin
			lbd_nxt = low_dir_in;
			hbd_nxt = high_dir_in;
		end
		dsel_nxt = (mode_v == PNL_MODE_CRT);
		mcs_oe_n_nxt = !power_down_n_input && pwr_r[`PNL_PWR_MEMCS_TRI];
		mcs_nxt = memcs16_in;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			upd_r <= 4'h0;
			lpd_r <= 4'h0;
			fp_r <= 1'b0;
			lp_r <= 1'b0;
			hs_r <= 1'b0;
			vs_r <= 1'b0;
			lbd_r <= 1'b0;
			hbd_r <= 1'b0;
			dsel_r <= 1'b1;
			mcs_r <= 1'b0;
			mcs_oe_n_r <= 1'b0;
		end else begin
			upd_r <= upd_nxt;
			lpd_r <= lpd_nxt;
			fp_r <= fp_nxt;
			lp_r <= lp_nxt;
			hs_r <= hs_nxt;
			vs_r <= vs_nxt;
			lbd_r <= lbd_nxt;
			hbd_r <= hbd_nxt;
			dsel_r <= dsel_nxt;
			mcs_r <= mcs_nxt;
			mcs_oe_n_r <= mcs_oe_n_nxt;
		end
	end

	assign upper_panel_data = upd_r;
	assign lower_panel_data = lpd_r;
	assign frame_pulse = fp_r;
	assign line_pulse = lp_r;
	assign crt_hsync = hs_r;
	assign crt_vsync = vs_r;
	assign low_byte_direction = lbd_r;
	assign high_byte_direction = hbd_r;
	assign display_select_out = dsel_r;
	assign memcs16_o = mcs_r;
	assign memcs16_oe_n = mcs_oe_n_r;
endmodule : pnl_output_control
`default_nettype wire

// [pkg/pnl_regs.svh]
// Register offsets, field positions and reset values of the panel output control block.
`ifndef PNL_REGS_SVH
`define PNL_REGS_SVH

`define PNL_OFS_MISC 8'h00
`define PNL_OFS_SYNC_ADJ 8'h04
`define PNL_OFS_EXT 8'h08
`define PNL_OFS_BUS_PWR 8'h0c
`define PNL_OFS_PANEL_CFG 8'h10
`define PNL_OFS_MISC_OUT 8'h14
`define PNL_OFS_STATUS 8'h18

`define PNL_RST_MISC 8'h00
`define PNL_RST_SYNC_ADJ 8'h00
`define PNL_RST_EXT 8'h00
`define PNL_RST_BUS_PWR 8'h00
`define PNL_RST_PANEL_CFG 8'h00
`define PNL_RST_MISC_OUT 8'h00

`define PNL_MISC_DAC_OFF 7
`define PNL_MISC_REVERSE 4

`define PNL_EXT_IO_EXT 4
`define PNL_EXT_TEXT_ONLY 3
`define PNL_EXT_SYNC_MUX 2
`define PNL_EXT_FP_INV 1
`define PNL_EXT_LP_INV 0

`define PNL_ADJ_DLY_MSB 7
`define PNL_ADJ_DLY_B1 1
`define PNL_ADJ_DLY_B0 0

`define PNL_PWR_MEMCS_TRI 5

`define PNL_MOUT_VSYNC_NEG 7
`define PNL_MOUT_HSYNC_NEG 6

`define PNL_CFG_MODE_LO 0
`define PNL_CFG_MODE_HI 1
`define PNL_CFG_TFT 2
`define PNL_CFG_STN_COLOR 3
`define PNL_CFG_MONO 4
`define PNL_CFG_LP_VBLANK 5
`define PNL_CFG_VEXP 6
`define PNL_CFG_SW_PWRDN 7

`define PNL_DLY_TAPS 7

`endif

// [pkg/pnl_pkg.sv]
// Types shared by the panel output control modules.
package pnl_pkg;
	typedef logic [7:0] pnl_byte_t;
	typedef logic [2:0] pnl_dly_t;
	typedef logic [3:0] pnl_nib_t;
	typedef enum logic [1:0] {
		PNL_MODE_CRT,
		PNL_MODE_PANEL,
		PNL_MODE_SIMUL,
		PNL_MODE_RSVD
	} pnl_mode_t;
endpackage : pnl_pkg

// [pkg/pnl_dly_if.sv]
// Link between the control logic and the horizontal sync delay line.
`timescale 1ns/100ps
`default_nettype none
interface pnl_dly_if;
	logic video_clock_en;
	logic sync_in;
	logic [2:0] delay;
	logic sync_out;
	modport ctl (output video_clock_en, output sync_in, output delay, input sync_out);
	modport dly (input video_clock_en, input sync_in, input delay, output sync_out);
endinterface : pnl_dly_if
`default_nettype wire

// [rtl/pnl_hsync_delay.sv]
// Delay line that holds back horizontal sync by zero to seven video clocks.
`timescale 1ns/100ps
`default_nettype none
`include "pnl_regs.svh"
module pnl_hsync_delay (
	// Clock and reset.
	input wire logic hclk,
	input wire logic hresetn,
	// Delay link.
	pnl_dly_if.dly dl
);
	import pnl_pkg::*;

	logic [`PNL_DLY_TAPS-1:0] tap_r;
	logic [`PNL_DLY_TAPS-1:0] tap_nxt;

	always_comb begin
		tap_nxt = tap_r;
		if (dl.video_clock_en) begin
			tap_nxt = {tap_r[`PNL_DLY_TAPS-2:0], dl.sync_in};
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tap_r <= '0;
		end else begin
			tap_r <= tap_nxt;
		end
	end

	always_comb begin
		if (dl.delay == 3'h0) begin
			dl.sync_out = dl.sync_in;
		end else begin
			dl.sync_out = tap_r[dl.delay - 3'h1];
		end
	end
endmodule : pnl_hsync_delay
`default_nettype wire

// [tb/pnl_output_control_assertions.sv]
// Concurrent checks on the ports of the panel output control block.
`timescale 1ns/100ps
`default_nettype none
module pnl_output_control_assertions (
	// Clock and reset.
	input wire logic hclk,
	input wire logic hresetn,
	// Bus.
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	input wire logic hreadyout,
	input wire logic hresp,
	// Pins and control.
	input wire logic video_clock,
	input wire logic power_down_n_input,
	input wire logic memcs16_in,
	input wire logic memcs16_o,
	input wire logic memcs16_oe_n,
	input wire logic display_select_out,
	input wire pnl_pkg::pnl_nib_t upper_panel_data,
	input wire pnl_pkg::pnl_nib_t lower_panel_data,
	input wire logic dac_shutdown,
	input wire logic io_cycle_ext,
	input wire logic dither_clk_en,
	input wire logic panel_enable,
	input wire logic crt_enable
);
	import pnl_pkg::*;
	logic wph_r;
	logic [7:0] adr_r;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// Marks the data phase of a write and the word it addresses.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wph_r <= 1'b0;
			adr_r <= 8'h00;
		end else begin
			wph_r <= hsel && htrans[1] && hready && hwrite;
			adr_r <= haddr;
		end
	end
	a_dac_write:
	assert property ((wph_r && adr_r == 8'h00) |=> dac_shutdown == $past(hwdata[7]))
		else $error("dac shutdown does not follow its bit");
	a_io_cycle:
	assert property ((wph_r && adr_r == 8'h08) |=> io_cycle_ext == $past(hwdata[4]))
		else $error("io cycle select does not follow its bit");
	a_bus_okay:
	assert property (hreadyout && !hresp) else $error("bus slave not ready or not okay");
	a_dsel_crt:
	assert property (($stable(crt_enable) && $stable(panel_enable)) |->
		display_select_out == (crt_enable && !panel_enable)) else $error("display select wrong");
	a_dither_gate:
	assert property (dither_clk_en |-> video_clock && panel_enable && power_down_n_input)
		else $error("dither clock runs while not needed");
	a_data_low:
	assert property (!power_down_n_input |=> upper_panel_data == 4'h0 && lower_panel_data == 4'h0)
		else $error("panel data not low in power-down");
	a_memcs_drive:
	assert property (power_down_n_input |=> !memcs16_oe_n) else $error("chip select released");
	a_memcs_copy:
	assert property (!memcs16_oe_n |-> memcs16_o == $past(memcs16_in))
		else $error("chip select copy wrong");
endmodule : pnl_output_control_assertions
bind pnl_output_control pnl_output_control_assertions i_pnl_output_control_assertions (
	.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hwdata, .hreadyout, .hresp,
	.video_clock, .power_down_n_input, .memcs16_in, .memcs16_o, .memcs16_oe_n,
	.display_select_out, .upper_panel_data, .lower_panel_data, .dac_shutdown, .io_cycle_ext,
	.dither_clk_en, .panel_enable, .crt_enable
);
`default_nettype wire

// [tb/pnl_panel_model.sv]
// Board side of the block: resolves the released memory chip-select line.
`timescale 1ns/100ps
`default_nettype none
module pnl_panel_model (
	// Pins from the block.
	input wire logic memcs16_o,
	input wire logic memcs16_oe_n,
	// Level seen on the board.
	output logic memcs16_bus
);
	assign memcs16_bus = memcs16_oe_n ? 1'b1 : memcs16_o;
endmodule : pnl_panel_model
`default_nettype wire

// [tb/testbench.sv]
// Self-checking bench of the panel output control block.
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import pnl_pkg::*;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, video_clock = 1'b1;
	logic crt_hsync_in = 1'b0, crt_vsync_in = 1'b0, frame_pulse_in = 1'b0, line_pulse_in = 1'b0;
	logic vblank_in = 1'b0, text_mode_in = 1'b0, low_dir_in = 1'b0, high_dir_in = 1'b0;
	logic memcs16_in = 1'b0, power_down_n_input = 1'b1;
	logic [7:0] haddr = 8'h00;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0, hrdata, junk;
	pnl_nib_t upper_data_in = 4'h0, lower_data_in = 4'h0, upper_panel_data, lower_panel_data;
	logic hreadyout, hresp, frame_pulse, line_pulse, crt_hsync, crt_vsync, low_byte_direction;
	logic high_byte_direction, display_select_out, memcs16_o, memcs16_oe_n, dac_shutdown;
	logic io_cycle_ext, dither_clk_en, color_4k_mode, vexp_center_en, panel_enable, crt_enable;
	logic memcs16_bus;
	wire logic hready;
	int mismatches = 0, check_count = 0;
	assign hready = hreadyout;
	always #50 hclk = ~hclk;
	// Video clock enable: a one-cycle pulse on every second bus clock.
	localparam int VIDEO_CLOCK_DIV = 2;
	always @(posedge hclk) video_clock <= ~video_clock;
	pnl_output_control i_pnl_output_control (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
		.hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .video_clock, .crt_hsync_in,
		.crt_vsync_in, .frame_pulse_in, .line_pulse_in, .vblank_in, .text_mode_in,
		.upper_data_in, .lower_data_in, .low_dir_in, .high_dir_in, .memcs16_in,
		.power_down_n_input, .upper_panel_data, .lower_panel_data, .frame_pulse, .line_pulse,
		.crt_hsync, .crt_vsync, .low_byte_direction, .high_byte_direction, .display_select_out,
		.memcs16_o, .memcs16_oe_n, .dac_shutdown, .io_cycle_ext, .dither_clk_en, .color_4k_mode,
		.vexp_center_en, .panel_enable, .crt_enable);
	pnl_panel_model i_pnl_panel_model (.memcs16_o, .memcs16_oe_n, .memcs16_bus);
	task end_sim;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : end_sim
	task ck(input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e) begin
			mismatches++;
			$display("BAD %0t got %h expected %h", $time, s, e);
		end
	endtask : ck
	task cy(input int n);
		repeat (n) @(posedge hclk);
		#1;
	endtask : cy
	task vk;
		if (video_clock !== 1'b1) cy(1);
	endtask : vk
	task wt;
		int i;
		i = 0;
		@(posedge hclk);
		while (hready !== 1'b1) begin
			i++;
			if (i > 50) begin
				mismatches++;
				end_sim();
			end
			@(posedge hclk);
		end
	endtask : wt
	task xf(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		wt();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wt();
		q = hrdata;
	endtask : xf
	task wr(input logic [7:0] a, input logic [7:0] d);
		xf(1'b1, a, {24'h0, d}, junk);
	endtask : wr
	task t_regs;
		logic [31:0] q;
		for (int a = 0; a < 32; a += 4) begin
			if (a != 24) xf(1'b0, a[7:0], 32'h0, q);
			if (a != 24) ck(q, 32'h0);
		end
		xf(1'b1, 8'h00, 32'hffff_ff80, q);
		xf(1'b0, 8'h00, 32'h0, q);
		ck(q, 32'h80);
		wr(8'h08, 8'h10);
		cy(1);
		ck(dac_shutdown, 1'b1);
		ck(io_cycle_ext, 1'b1);
		wr(8'h00, 8'h00);
		wr(8'h08, 8'h00);
		cy(1);
		ck(dac_shutdown, 1'b0);
		ck(io_cycle_ext, 1'b0);
		$display("regs done");
	endtask : t_regs
	task t_mode;
		for (int m = 0; m < 4; m++) begin
			wr(8'h10, 8'h48 | m[7:0]);
			cy(4);
			vk();
			ck(display_select_out, m == 0);
			ck(crt_enable, m == 0 || m == 2);
			ck(panel_enable, m == 1 || m == 2);
			ck(dither_clk_en, m == 1 || m == 2);
			ck(vexp_center_en, m == 1 || m == 2);
			ck(color_4k_mode, m == 1 || m == 2);
		end
		wr(8'h10, 8'h41);
		cy(4);
		vk();
		ck(dither_clk_en, 1'b0);
		ck(color_4k_mode, 1'b0);
		$display("mode done");
	endtask : t_mode
	task t_pol;
		wr(8'h10, 8'h09);
		@(posedge hclk);
		frame_pulse_in <= 1'b1;
		line_pulse_in <= 1'b1;
		for (int e = 0; e < 4; e++) begin
			wr(8'h08, e[7:0]);
			cy(4);
			ck(line_pulse, !e[0]);
			ck(frame_pulse, !e[1]);
		end
		wr(8'h08, 8'h00);
		@(posedge hclk);
		vblank_in <= 1'b1;
		cy(4);
		ck(line_pulse, 1'b0);
		wr(8'h10, 8'h29);
		cy(4);
		ck(line_pulse, 1'b1);
		@(posedge hclk);
		vblank_in <= 1'b0;
		$display("pol done");
	endtask : t_pol
	task t_rev;
		logic r;
		wr(8'h10, 8'h11);
		@(posedge hclk);
		upper_data_in <= 4'h5;
		lower_data_in <= 4'h3;
		for (int i = 0; i < 8; i++) begin
			wr(8'h00, {3'h0, i[2], 4'h0});
			wr(8'h08, {4'h0, i[1], 3'h0});
			@(posedge hclk);
			text_mode_in <= i[0];
			cy(4);
			r = i[2] & (i[0] | !i[1]);
			ck(upper_panel_data, 4'h5 ^ {4{r}});
			ck(lower_panel_data, 4'h3 ^ {4{r}});
		end
		wr(8'h00, 8'h00);
		$display("rev done");
	endtask : t_rev
	task t_sync;
		wr(8'h10, 8'h01);
		wr(8'h08, 8'h04);
		@(posedge hclk);
		crt_vsync_in <= 1'b1;
		crt_hsync_in <= 1'b1;
		high_dir_in <= 1'b1;
		cy(12);
		ck(low_byte_direction, 1'b1);
		ck(crt_vsync, 1'b1);
		wr(8'h14, 8'hc0);
		cy(12);
		ck(crt_vsync, 1'b0);
		ck(crt_hsync, 1'b0);
		wr(8'h14, 8'h00);
		wr(8'h10, 8'h05);
		cy(12);
		ck(crt_vsync, 1'b0);
		ck(crt_hsync, 1'b0);
		ck(high_byte_direction, 1'b0);
		wr(8'h08, 8'h00);
		wr(8'h10, 8'h01);
		cy(4);
		ck(high_byte_direction, 1'b1);
		ck(low_byte_direction, 1'b0);
		@(posedge hclk);
		crt_hsync_in <= 1'b0;
		$display("sync done");
	endtask : t_sync
	task t_dly;
		int l;
		for (int n = 0; n < 8; n++) begin
			wr(8'h04, {n[2], 5'h0, n[1:0]});
			cy(16);
			// Raise sync so that the very next edge is a video clock.
			if (video_clock !== 1'b0) cy(1);
			@(posedge hclk);
			crt_hsync_in <= 1'b1;
			l = 0;
			cy(1);
			while (crt_hsync !== 1'b1 && l < 40) begin
				l++;
				cy(1);
			end
			ck(l, n * VIDEO_CLOCK_DIV);
			if (l >= 40) end_sim();
			@(posedge hclk);
			crt_hsync_in <= 1'b0;
		end
		$display("delay done");
	endtask : t_dly
	task t_pwr;
		wr(8'h0c, 8'h20);
		@(posedge hclk);
		upper_data_in <= 4'hf;
		cy(4);
		ck(memcs16_bus, 1'b0);
		@(posedge hclk);
		power_down_n_input <= 1'b0;
		cy(2);
		ck(memcs16_oe_n, 1'b1);
		ck(memcs16_bus, 1'b1);
		ck(upper_panel_data, 4'h0);
		wr(8'h0c, 8'h00);
		@(posedge hclk);
		memcs16_in <= 1'b1;
		cy(2);
		ck(memcs16_oe_n, 1'b0);
		ck(memcs16_bus, 1'b1);
		ck(memcs16_o, 1'b1);
		@(posedge hclk);
		power_down_n_input <= 1'b1;
		cy(4);
		ck(upper_panel_data, 4'hf);
		wr(8'h10, 8'h81);
		cy(4);
		ck(upper_panel_data, 4'h0);
		$display("power done");
	endtask : t_pwr
	initial begin
		repeat (3) @(posedge hclk);
		#1;
		ck(display_select_out, 1'b1);
		ck(upper_panel_data, 4'h0);
		@(posedge hclk);
		hresetn <= 1'b1;
		t_regs();
		t_mode();
		t_pol();
		t_rev();
		t_sync();
		t_dly();
		t_pwr();
		end_sim();
	end
endmodule : testbench
`default_nettype wire
